/* inc/pps_regs.vh */
`ifndef PPS_REGS_VH
`define PPS_REGS_VH

// Register offsets
`define PPS_ADDR_TRIM      8'h08
`define PPS_ADDR_OVR       8'h09
`define PPS_ADDR_PCLK      8'h0d
`define PPS_ADDR_SDF       8'h14
`define PPS_ADDR_DIV       8'h18
`define PPS_ADDR_CP        8'h1b
`define PPS_ADDR_OSEL      8'h1e
`define PPS_ADDR_LPF       8'h1f
`define PPS_ADDR_PCFG      8'h30

// Reset values
`define PPS_RST_TRIM       8'h00
`define PPS_RST_OVR        8'h00
`define PPS_RST_PCLK       8'h00
`define PPS_RST_SDF        8'h00
`define PPS_RST_DIV        8'h00
`define PPS_RST_CP         8'h03
`define PPS_RST_OSEL       8'he0
`define PPS_RST_LPF        8'h00
`define PPS_RST_PCFG       8'h00
`define PPS_RD_UNMAPPED    8'h00

// Override control bits
`define PPS_OVR_CAP        7
`define PPS_OVR_LPF        6
`define PPS_OVR_MUX        5
`define PPS_OVR_CP         3
`define PPS_OVR_DIV        2

// Field positions
`define PPS_PCLK_RUN       5
`define PPS_SDF_FORCE      7
`define PPS_SDF_OFF        6
`define PPS_OSEL_PEN       4
`define PPS_OSEL_MSB       7
`define PPS_OSEL_LSB       5
`define PPS_PCFG_LOAD      3
`define PPS_PCFG_RUNSTAT   7
`define PPS_PCFG_LOCKSTAT  6
`define PPS_SEL_MSB        1
`define PPS_SEL_LSB        0
`define PPS_DIV_MSB        6
`define PPS_DIV_LSB        4
`define PPS_CODE_MSB       4
`define PPS_CODE_LSB       0

// Output select codes
`define PPS_OUT_RAW        3'h0
`define PPS_OUT_RETIMED    3'h1
`define PPS_OUT_ICLK       3'h2
`define PPS_OUT_QCLK       3'h3
`define PPS_OUT_PATTERN    3'h4
`define PPS_OUT_OSC        3'h5
`define PPS_OUT_INVALID    3'h6
`define PPS_OUT_MUTE       3'h7

// Sequence codes, divider limits, charge pump off code
`define PPS_SEQ_PRBS9      2'h0
`define PPS_SEQ_PRBS31     2'h2
`define PPS_DIV_MAX        3'h4
`define PPS_CP_OFF         2'h0
`define PPS_RATIO_ONE      5'h01

// Generator taps and seed
`define PPS_SEED           31'h7fffffff
`define PPS_TAP9_A         8
`define PPS_TAP9_B         4
`define PPS_TAP31_A        30
`define PPS_TAP31_B        27
`define PPS_SHORT_MSB      8
`define PPS_WORD_BITS      8
`define PPS_FIFO_DEPTH     8

`endif

/* hw/pps_fifo.v */
`timescale 1ns/100ps
// Word FIFO with a registered output stage
module pps_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             resetn_in,
  // Fill side
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  // Drain side
  output reg  [WIDTH-1:0] out_data_out,
  output reg              out_valid_out,
  input  wire             out_ready_in
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wptr_reg;
  reg [AW-1:0]    rptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // Full only when every slot holds a word, so the source really stalls
  assign in_ready_out = (count_reg != DEPTH[AW:0]);
  assign push         = in_valid_in & in_ready_out;
  assign pop          = (count_reg != {(AW+1){1'b0}}) & (~out_valid_out | out_ready_in);

  // Storage has no reset; only pointers and flags need a defined value
  always @(posedge clk_in) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_in;
    end
  end

  // Pointers, count and output register
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wptr_reg      <= {AW{1'b0}};
      rptr_reg      <= {AW{1'b0}};
      count_reg     <= {(AW+1){1'b0}};
      out_data_out  <= {WIDTH{1'b0}};
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg     <= rptr_reg + 1'b1;
        out_data_out <= mem_reg[rptr_reg];
      end
      if (pop) begin
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // pps_fifo

/* hw/pps_top.v */
`timescale 1ns/100ps
`include "pps_regs.vh"
module pps_top (
  // Clock and reset
  input  wire       clk_in,
  input  wire       resetn_in,
  // Register access
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_ack_out,
  // Analog status from the channel front end
  input  wire       signal_present_in,
  input  wire       cdr_locked_in,
  // Settings chosen by the lock machine
  input  wire [2:0] auto_divider_in,
  input  wire [4:0] auto_cap_in,
  // Pattern stream toward the serialiser
  output wire [7:0] pattern_data_out,
  output wire       pattern_valid_out,
  input  wire       pattern_ready_in,
  // Channel and VCO controls
  output reg        channel_enable_out,
  output reg        signal_detect_out,
  output reg  [2:0] output_select_out,
  output reg        free_run_out,
  output reg        charge_pump_enable_out,
  output reg  [2:0] divider_code_out,
  output reg  [4:0] divider_ratio_out,
  output reg  [4:0] cap_trim_out,
  output reg        loop_filter_voltage_dac_enable_out,
  output reg  [4:0] loop_filter_voltage_dac_code_out,
  output reg        pattern_running_out
);

  // Configuration registers
  reg  [7:0]  trim_reg;
  reg  [7:0]  ovr_reg;
  reg  [7:0]  pclk_reg;
  reg  [7:0]  sdf_reg;
  reg  [7:0]  div_reg;
  reg  [7:0]  cp_reg;
  reg  [7:0]  osel_reg;
  reg  [7:0]  lpf_reg;
  reg  [7:0]  pcfg_reg;

  // Synchronisers for the asynchronous front-end status
  reg         sigp_meta_reg;
  reg         sigp_sync_reg;
  reg         lock_meta_reg;
  reg         lock_sync_reg;

  // Generator state, and the next values of the read, select and divider muxes
  reg  [30:0] lfsr_reg;
  reg  [7:0]  rd_next;
  reg  [2:0]  sel_next;
  reg  [2:0]  div_next;

  wire        sig_detect;
  wire        gen_loaded;
  wire        gen_running;
  wire        seq_long;
  wire        zero_state;
  wire        fifo_ready;
  wire [7:0]  gen_word;
  wire [30:0] chain [0:`PPS_WORD_BITS];
  wire [2:0]  osel_field;
  wire [2:0]  div_field;

  assign osel_field = osel_reg[`PPS_OSEL_MSB:`PPS_OSEL_LSB];
  assign div_field  = div_reg[`PPS_DIV_MSB:`PPS_DIV_LSB];

  // Two flops before any logic looks at the front-end levels
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sigp_meta_reg <= 1'b0;
      sigp_sync_reg <= 1'b0;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      sigp_meta_reg <= signal_present_in;
      sigp_sync_reg <= sigp_meta_reg;
      lock_meta_reg <= cdr_locked_in;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  // Register writes; unmapped writes are dropped
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trim_reg <= `PPS_RST_TRIM;
      ovr_reg  <= `PPS_RST_OVR;
      pclk_reg <= `PPS_RST_PCLK;
      sdf_reg  <= `PPS_RST_SDF;
      div_reg  <= `PPS_RST_DIV;
      cp_reg   <= `PPS_RST_CP;
      osel_reg <= `PPS_RST_OSEL;
      lpf_reg  <= `PPS_RST_LPF;
      pcfg_reg <= `PPS_RST_PCFG;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `PPS_ADDR_TRIM: trim_reg <= reg_wdata_in;
        `PPS_ADDR_OVR:  ovr_reg  <= reg_wdata_in;
        `PPS_ADDR_PCLK: pclk_reg <= reg_wdata_in;
        `PPS_ADDR_SDF:  sdf_reg  <= reg_wdata_in;
        `PPS_ADDR_DIV:  div_reg  <= reg_wdata_in;
        `PPS_ADDR_CP:   cp_reg   <= reg_wdata_in;
        `PPS_ADDR_OSEL: osel_reg <= reg_wdata_in;
        `PPS_ADDR_LPF:  lpf_reg  <= reg_wdata_in;
        `PPS_ADDR_PCFG: pcfg_reg <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Read mux; two status bits of the pattern config read live state
  always @* begin
    rd_next = `PPS_RD_UNMAPPED;
    case (reg_addr_in)
      `PPS_ADDR_TRIM: rd_next = trim_reg;
      `PPS_ADDR_OVR:  rd_next = ovr_reg;
      `PPS_ADDR_PCLK: rd_next = pclk_reg;
      `PPS_ADDR_SDF:  rd_next = sdf_reg;
      `PPS_ADDR_DIV:  rd_next = div_reg;
      `PPS_ADDR_CP:   rd_next = cp_reg;
      `PPS_ADDR_OSEL: rd_next = osel_reg;
      `PPS_ADDR_LPF:  rd_next = lpf_reg;
      `PPS_ADDR_PCFG: begin
        rd_next = pcfg_reg;
        rd_next[`PPS_PCFG_RUNSTAT]  = gen_running;
        rd_next[`PPS_PCFG_LOCKSTAT] = lock_sync_reg;
      end
      default: rd_next = `PPS_RD_UNMAPPED;
    endcase
  end

  // Answer one cycle after each access
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= `PPS_RD_UNMAPPED;
      reg_ack_out   <= 1'b0;
    end else begin
      reg_ack_out <= reg_wr_in | reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_next;
      end
    end
  end

  // Forced detect needs bit 6 clear, else the front end decides
  assign sig_detect = (sdf_reg[`PPS_SDF_FORCE] & ~sdf_reg[`PPS_SDF_OFF]) | sigp_sync_reg;

  // Generator enable chain: logic enable, clock load, clock run
  assign gen_loaded  = osel_reg[`PPS_OSEL_PEN] & pcfg_reg[`PPS_PCFG_LOAD];
  assign gen_running = gen_loaded & pclk_reg[`PPS_PCLK_RUN];
  assign seq_long    = (pcfg_reg[`PPS_SEL_MSB:`PPS_SEL_LSB] == `PPS_SEQ_PRBS31);

  // Short sequence lives in the low nine bits only
  assign zero_state = seq_long ? (lfsr_reg == 31'h0) :
                                 (lfsr_reg[`PPS_SHORT_MSB:0] == 9'h000);

  // Eight serial steps per word, first bit out in the word MSB
  assign chain[0] = lfsr_reg;
  genvar gi;
  generate
    for (gi = 0; gi < `PPS_WORD_BITS; gi = gi + 1) begin : g_step
      wire fb9;
      wire fb31;
      assign fb9  = chain[gi][`PPS_TAP9_A] ^ chain[gi][`PPS_TAP9_B];
      assign fb31 = chain[gi][`PPS_TAP31_A] ^ chain[gi][`PPS_TAP31_B];
      assign chain[gi+1] = seq_long ? {chain[gi][29:0], fb31} :
                                      {22'h000000, chain[gi][7:0], fb9};
      assign gen_word[`PPS_WORD_BITS-1-gi] = seq_long ? fb31 : fb9;
    end
  endgenerate

  // Sequencer holds at the seed while the pattern clock is in reset
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lfsr_reg <= `PPS_SEED;
    end else if (!gen_loaded) begin
      lfsr_reg <= `PPS_SEED;
    end else if (zero_state) begin
      lfsr_reg <= `PPS_SEED;
    end else if (gen_running && fifo_ready) begin
      lfsr_reg <= chain[`PPS_WORD_BITS];
    end
  end

  // Stalls the sequencer when the drain side stops taking words
  pps_fifo #(
    .WIDTH (`PPS_WORD_BITS),
    .DEPTH (`PPS_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_data_in    (gen_word),
    .in_valid_in   (gen_running & ~zero_state),
    .in_ready_out  (fifo_ready),
    .out_data_out  (pattern_data_out),
    .out_valid_out (pattern_valid_out),
    .out_ready_in  (pattern_ready_in)
  );

  // Effective output source; unknown code and idle pattern both mute
  always @* begin
    sel_next = `PPS_OUT_MUTE;
    if (!sig_detect) begin
      sel_next = `PPS_OUT_MUTE;
    end else if (lock_sync_reg && !ovr_reg[`PPS_OVR_MUX]) begin
      sel_next = `PPS_OUT_RETIMED;
    end else begin
      case (osel_field)
        `PPS_OUT_PATTERN: sel_next = gen_running ? `PPS_OUT_PATTERN : `PPS_OUT_MUTE;
        `PPS_OUT_INVALID: sel_next = `PPS_OUT_MUTE;
        `PPS_OUT_RAW,
        `PPS_OUT_RETIMED,
        `PPS_OUT_ICLK,
        `PPS_OUT_QCLK,
        `PPS_OUT_OSC,
        `PPS_OUT_MUTE:    sel_next = osel_field;
        default:          sel_next = `PPS_OUT_MUTE;
      endcase
    end
  end

  // Codes above the top ratio stay at divide by sixteen
  always @* begin
    div_next = auto_divider_in;
    if (ovr_reg[`PPS_OVR_DIV]) begin
      div_next = (div_field > `PPS_DIV_MAX) ? `PPS_DIV_MAX : div_field;
    end else if (auto_divider_in > `PPS_DIV_MAX) begin
      div_next = `PPS_DIV_MAX;
    end
  end

  // All controls leave through flops; the mux never touches the loop
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      channel_enable_out     <= 1'b0;
      signal_detect_out      <= 1'b0;
      output_select_out      <= `PPS_OUT_MUTE;
      free_run_out           <= 1'b0;
      charge_pump_enable_out <= 1'b1;
      divider_code_out       <= 3'h0;
      divider_ratio_out      <= `PPS_RATIO_ONE;
      cap_trim_out           <= 5'h00;
      loop_filter_voltage_dac_enable_out     <= 1'b0;
      loop_filter_voltage_dac_code_out       <= 5'h00;
      pattern_running_out    <= 1'b0;
    end else begin
      channel_enable_out  <= sig_detect;
      signal_detect_out   <= sig_detect;
      output_select_out   <= sel_next;
      // Pump off only with both the override and the off code
      charge_pump_enable_out <= ~(ovr_reg[`PPS_OVR_CP] &
                                  (cp_reg[`PPS_SEL_MSB:`PPS_SEL_LSB] == `PPS_CP_OFF));
      // Locked VCO clocks the pattern unless the loop is opened
      free_run_out <= (ovr_reg[`PPS_OVR_CP] &
                       (cp_reg[`PPS_SEL_MSB:`PPS_SEL_LSB] == `PPS_CP_OFF)) |
                      ~lock_sync_reg;
      divider_code_out  <= div_next;
      divider_ratio_out <= `PPS_RATIO_ONE << div_next;
      cap_trim_out      <= ovr_reg[`PPS_OVR_CAP] ?
                           trim_reg[`PPS_CODE_MSB:`PPS_CODE_LSB] : auto_cap_in;
      loop_filter_voltage_dac_enable_out <= ovr_reg[`PPS_OVR_LPF];
      loop_filter_voltage_dac_code_out   <= lpf_reg[`PPS_CODE_MSB:`PPS_CODE_LSB];
      pattern_running_out <= gen_running;
    end
  end

endmodule // pps_top

/* sim/pps_checker_properties.sv */
`timescale 1ns/100ps
// Port-level checks on the channel pattern source
module pps_checker (
  // Clock and reset
  input wire       clk_in,
  input wire       resetn_in,
  // Register access
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_ack_out,
  // Pattern stream
  input wire [7:0] pattern_data_out,
  input wire       pattern_valid_out,
  input wire       pattern_ready_in,
  // Channel and VCO controls
  input wire       signal_detect_out,
  input wire [2:0] output_select_out,
  input wire       free_run_out,
  input wire       charge_pump_enable_out,
  input wire [2:0] divider_code_out,
  input wire [4:0] divider_ratio_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // Every strobe answered next cycle, and only a strobe
  property p_ack_after_strobe;
    (reg_wr_in || reg_rd_in) |=> reg_ack_out;
  endproperty
  a_ack_after_strobe: assert property (p_ack_after_strobe)
    else $error("strobe not acknowledged");
  property p_no_stray_ack;
    !(reg_wr_in || reg_rd_in) |=> !reg_ack_out;
  endproperty
  a_no_stray_ack: assert property (p_no_stray_ack)
    else $error("ack without strobe");
  // Read data holds between reads
  property p_rdata_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without read");
  // Divider ratio follows the code, code never above 4
  property p_ratio_map;
    divider_ratio_out == (5'h01 << divider_code_out);
  endproperty
  a_ratio_map: assert property (p_ratio_map)
    else $error("divider ratio mismatch");
  property p_div_range;
    divider_code_out <= 3'h4;
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("divider code out of range");
  // Invalid select never reaches the mux
  property p_no_invalid_sel;
    output_select_out != 3'h6;
  endproperty
  a_no_invalid_sel: assert property (p_no_invalid_sel)
    else $error("invalid output select");
  // Two cycles without detect; the select is registered on the same edge as detect, so there is no mux lag
  property p_mute_no_detect;
    (!signal_detect_out) [*2] |-> output_select_out == 3'h7;
  endproperty
  a_mute_no_detect: assert property (p_mute_no_detect)
    else $error("output not muted without detect");
  property p_pump_off_free;
    !charge_pump_enable_out |-> free_run_out;
  endproperty
  a_pump_off_free: assert property (p_pump_off_free)
    else $error("pump off but VCO not free running");
  // Stalled word stays put
  property p_word_hold;
    pattern_valid_out && !pattern_ready_in |=> pattern_valid_out && $stable(pattern_data_out);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("stalled pattern word changed");
endmodule // pps_checker

bind pps_top pps_checker u_checker (.*);

/* sim/pps_sink.sv */
`timescale 1ns/100ps
// Downstream receiver; stalls at random, or fully while held
module pps_sink (
  // Clock and reset
  input  wire clk_in,
  input  wire resetn_in,
  // Stall request from the bench
  input  wire hold_in,
  // Pattern stream
  output reg  pattern_ready_out
);
  integer seed = 42;

  // About one cycle in four refused, so the fifo sees back pressure
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      pattern_ready_out <= 1'b0;
    else
      pattern_ready_out <= !hold_in && (($random(seed) & 3) != 0);
  end
endmodule // pps_sink

/* sim/tb_top.sv */
`timescale 1ns/100ps
`include "pps_regs.vh"
`define CHK(n, e, g) \
  begin \
    total_checks = total_checks + 1; \
    if ((g) !== (e)) begin \
      num_errors = num_errors + 1; \
      $display("ERROR %s expected %h seen %h", n, e, g); \
    end \
  end
// Self-checking bench for the channel pattern source
module tb_top;
  localparam [79:0] ADDRS = 80'h08_09_0d_14_18_1b_1e_1f_30_55;
  localparam [79:0] RSTS  = {`PPS_RST_TRIM, `PPS_RST_OVR, `PPS_RST_PCLK, `PPS_RST_SDF,
    `PPS_RST_DIV, `PPS_RST_CP, `PPS_RST_OSEL, `PPS_RST_LPF, `PPS_RST_PCFG, `PPS_RD_UNMAPPED};
  reg        clk_in, resetn_in, reg_wr_in, reg_rd_in, signal_present_in, cdr_locked_in, hold;
  reg  [7:0] reg_addr_in, reg_wdata_in, q, w;
  reg  [7:0] mem [0:9];
  reg  [2:0] auto_divider_in;
  reg  [4:0] auto_cap_in;
  wire       pattern_ready_in, reg_ack_out, pattern_valid_out, channel_enable_out;
  wire       signal_detect_out, free_run_out, charge_pump_enable_out;
  wire       loop_filter_voltage_dac_enable_out, pattern_running_out;
  wire [7:0] reg_rdata_out, pattern_data_out;
  wire [2:0] output_select_out, divider_code_out;
  wire [4:0] divider_ratio_out, cap_trim_out, loop_filter_voltage_dac_code_out;
  integer    num_errors, total_checks, seed, i, j, k;
  reg        bits [$];

  pps_top dut (.*);
  pps_sink u_sink (.clk_in(clk_in), .resetn_in(resetn_in), .hold_in(hold),
    .pattern_ready_out(pattern_ready_in));

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Bits taken by the sink, first in time first
  always @(posedge clk_in) begin
    if (resetn_in && pattern_valid_out === 1'b1 && pattern_ready_in === 1'b1)
      for (k = 0; k < 8; k = k + 1) bits.push_back(pattern_data_out[7-k]);
  end

  function [7:0] ad(input integer n);
    ad = ADDRS[79-8*n -: 8];
  endfunction

  task conclude;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // One strobe, ack one cycle later, read data kept in q
  task acc(input wr_en, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      reg_wr_in <= wr_en;
      reg_rd_in <= !wr_en;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      #1;
      `CHK("ack", 1'b1, reg_ack_out)
      q = reg_rdata_out;
    end
  endtask

  // Write, then let the controls settle
  task wr(input [7:0] a, input [7:0] d);
    begin
      acc(1'b1, a, d);
      repeat (2) @(posedge clk_in);
      #1;
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      acc(1'b0, a, 8'h00);
      `CHK("rdata", e, q)
    end
  endtask

  task do_reset;
    begin
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
    end
  endtask

  // Stop, drain, restart with one sequence; check its recurrence
  task run_seq(input [1:0] s, input integer n, input integer tap);
    begin
      wr(8'h0d, 8'h00);
      repeat (40) @(posedge clk_in);
      bits.delete();
      wr(8'h1e, 8'h90);
      wr(8'h30, {6'h00, s});
      wr(8'h30, {6'h02, s});
      wr(8'h0d, 8'h20);
      `CHK("running", 1'b1, pattern_running_out)
      `CHK("sel_pattern", 3'h4, output_select_out)
      rd(8'h30, {6'h22, s});
      @(posedge clk_in);
      hold <= 1'b1;
      repeat (30) @(posedge clk_in);
      #1;
      `CHK("full_valid", 1'b1, pattern_valid_out)
      hold <= 1'b0;
      for (i = 0; i < 3000 && bits.size() < 256; i = i + 1) @(posedge clk_in);
      // A short queue counts one mismatch; the run still reaches the report
      `CHK("pattern_fill", 1'b1, bits.size() >= 256)
      w = 8'h00;
      for (i = 0; i < 256 && i < bits.size(); i = i + 1) begin
        if (i >= n) `CHK("prbs_bit", bits[i-n] ^ bits[i-tap], bits[i])
        w[0] = w[0] | bits[i];
      end
      `CHK("prbs_nonzero", 1'b1, w[0])
    end
  endtask

  initial begin
    seed = 42;
    num_errors = 0;
    total_checks = 0;
    {resetn_in, reg_wr_in, reg_rd_in, signal_present_in, cdr_locked_in, hold} = 6'h00;
    {reg_addr_in, reg_wdata_in, auto_divider_in} = 19'h00000;
    auto_cap_in = $random(seed);
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    // Reset values and unmapped read
    for (j = 0; j < 10; j = j + 1) rd(ad(j), RSTS[79-8*j -: 8]);
    `CHK("sel_reset", 3'h7, output_select_out)
    `CHK("chan_reset", 1'b0, channel_enable_out)
    $display("test reset done");
    // Random write and readback, status bits of pattern config
    for (j = 0; j < 10; j = j + 1) begin
      mem[j] = $random(seed);
      acc(1'b1, ad(j), mem[j]);
    end
    for (j = 0; j < 10; j = j + 1) begin
      w = (j == 9) ? 8'h00 : mem[j];
      if (j == 8) w[7:6] = {mem[6][4] & mem[8][3] & mem[2][5], 1'b0};
      rd(ad(j), w);
    end
    do_reset;
    $display("test readback done");
    // Free run without input, overrides added one at a time
    wr(8'h14, 8'hc0);
    `CHK("detect_off", 1'b0, signal_detect_out)
    wr(8'h14, 8'h80);
    `CHK("detect", 1'b1, signal_detect_out)
    `CHK("chan_en", 1'b1, channel_enable_out)
    wr(8'h09, 8'h08);
    `CHK("pump_on", 1'b1, charge_pump_enable_out)
    wr(8'h1b, 8'h00);
    `CHK("pump_off", 1'b0, charge_pump_enable_out)
    `CHK("free_run", 1'b1, free_run_out)
    wr(8'h09, 8'h0c);
    for (j = 0; j < 8; j = j + 1) begin
      w = j;
      wr(8'h18, {1'b0, w[2:0], 4'h0});
      w[2:0] = (j > 4) ? 3'h4 : w[2:0];
      `CHK("div_code", w[2:0], divider_code_out)
      `CHK("div_ratio", 5'h01 << w[2:0], divider_ratio_out)
    end
    wr(8'h09, 8'h8c);
    wr(8'h08, 8'h0c);
    `CHK("cap", 5'h0c, cap_trim_out)
    wr(8'h09, 8'hcc);
    wr(8'h1f, 8'h12);
    `CHK("lpf_en", 1'b1, loop_filter_voltage_dac_enable_out)
    `CHK("lpf_code", 5'h12, loop_filter_voltage_dac_code_out)
    wr(8'h09, 8'hec);
    for (j = 0; j < 8; j = j + 1) begin
      w = j;
      wr(8'h1e, {w[2:0], 5'h10});
      `CHK("sel", (j == 6 || j == 4) ? 3'h7 : w[2:0], output_select_out)
    end
    run_seq(2'h0, 9, 5);
    run_seq(2'h2, 31, 28);
    wr(8'h1e, 8'h50);
    `CHK("sel_iclk", 3'h2, output_select_out)
    wr(8'h1e, 8'h90);
    `CHK("sel_back", 3'h4, output_select_out)
    wr(8'h09, 8'h00);
    rd(8'h09, 8'h00);
    `CHK("pump_back", 1'b1, charge_pump_enable_out)
    `CHK("cap_auto", auto_cap_in, cap_trim_out)
    `CHK("lpf_off", 1'b0, loop_filter_voltage_dac_enable_out)
    do_reset;
    $display("test free run done");
    // Locked channel: default retimed, override follows the field
    @(posedge clk_in);
    signal_present_in <= 1'b1;
    cdr_locked_in <= 1'b1;
    for (j = 0; j < 8; j = j + 1) begin
      @(posedge clk_in);
      auto_divider_in <= j;
      repeat (4) @(posedge clk_in);
      #1;
      `CHK("div_auto", (j > 4) ? 3'h4 : auto_divider_in, divider_code_out)
    end
    wr(8'h1e, 8'h40);
    `CHK("sel_locked", 3'h1, output_select_out)
    `CHK("locked_run", 1'b0, free_run_out)
    wr(8'h09, 8'h20);
    `CHK("sel_ovr", 3'h2, output_select_out)
    `CHK("stay_lock", 1'b0, free_run_out)
    @(posedge clk_in);
    signal_present_in <= 1'b0;
    cdr_locked_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("no_detect", 1'b0, signal_detect_out)
    `CHK("chan_off", 1'b0, channel_enable_out)
    `CHK("sel_mute", 3'h7, output_select_out)
    $display("test locked done");
    conclude;
  end
endmodule // tb_top
